// ===== verilog/trs_pkg.sv
// Constants and types shared by the transceiver reconfiguration streamer.
// Assumes a single 200 MHz clock with a synchronous active-high reset.
package trs_pkg;
   localparam logic [6:0] ADDR_LCH = 7'h38;
   localparam logic [6:0] ADDR_PCH = 7'h39;
   localparam logic [6:0] ADDR_CSR = 7'h3A;
   localparam logic [6:0] ADDR_OFS = 7'h3B;
   localparam logic [6:0] ADDR_DAT = 7'h3C;
   localparam int CSR_WR = 0;
   localparam int CSR_RD = 1;
   localparam int CSR_MODE_LO = 2;
   localparam int CSR_BUSY = 8;
   localparam int CSR_ERR = 9;
   localparam logic [1:0] MODE_STREAM = 2'h0;
   localparam logic [1:0] MODE_DIRECT = 2'h1;
   localparam logic [15:0] IREG_BASE = 16'h0000;
   localparam logic [15:0] IREG_CLR = 16'h0001;
   localparam logic [15:0] IREG_START = 16'h0002;
   localparam int ERR_ACCESS = 0;
   localparam int ERR_OPCODE = 1;
   localparam int ERR_PLL = 2;
   localparam int ERR_MISMATCH = 4;
   localparam logic [4:0] OPC_START = 5'h01;
   localparam logic [4:0] OPC_FORMAT = 5'h02;
   localparam logic [4:0] OPC_CDR_SW = 5'h03;
   localparam logic [4:0] OPC_PLL_SW = 5'h04;
   localparam logic [4:0] OPC_END = 5'h1F;
   localparam int REC_LEN_LO = 11;
   localparam int REC_TYPE_LO = 5;
   localparam logic [15:0] XCVR_OFS_LIMIT = 16'h0800;
   localparam logic [15:0] XCVR_CDR_SW_OFS = 16'h0800;
   localparam logic [15:0] XCVR_PLL_SW_OFS = 16'h0801;
   localparam logic [15:0] PROT_OFS_LO = 16'h0010;
   localparam logic [15:0] PROT_OFS_HI = 16'h0013;
   localparam logic [31:0] PROT_MASK = 32'h0000_00FF;
   localparam int NUM_CH = 4;
   localparam logic [2*NUM_CH-1:0] CHAN_TYPE_TABLE = 8'h00;
   localparam logic [9:0] PHYS_BASE = 10'h000;
   localparam int STD_TX_WIDTH = 44;
   localparam int STD_RX_WIDTH = 64;
   localparam int LANE_SLOT = 64;
   localparam int NUM_LANES = 3;
   typedef enum logic [3:0] {
      ST_IDLE, ST_XREAD, ST_XWRITE, ST_FETCH, ST_WAIT, ST_SWRITE
   } trs_state_e;
endpackage

// ===== verilog/trs_chan_map.sv
// Logical to physical channel translation table for the streamer.
// Assumes the logical channel comes from logic on the same clock.
`timescale 1ns/1ps
module trs_chan_map (
   input wire logic core_clk, // System clock.
   input wire logic sys_rst, // Synchronous reset, active high.
   input wire logic [9:0] logical_ch, // Logical channel number.
   output logic [9:0] phys_reg, // Physical channel address.
   output logic valid_reg, // Logical channel exists.
   output logic [1:0] type_reg // Channel type of the logical channel.
);
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         phys_reg <= 10'h000;
         valid_reg <= 1'b0;
         type_reg <= 2'h0;
      end else if (logical_ch < 10'(trs_pkg::NUM_CH)) begin
         phys_reg <= trs_pkg::PHYS_BASE + logical_ch;
         valid_reg <= 1'b1;
         type_reg <= trs_pkg::CHAN_TYPE_TABLE[2*logical_ch[1:0] +: 2];
      end else begin
         phys_reg <= 10'h000;
         valid_reg <= 1'b0;
         type_reg <= 2'h0;
      end
   end
endmodule

// ===== verilog/trs_streamer.sv
// Streamer of the transceiver reconfiguration controller.
// Assumes the management port, image memory and transceiver port share core_clk.
`timescale 1ns/1ps
module trs_streamer (
   input wire logic core_clk, // System clock, 200 MHz.
   input wire logic sys_rst, // Synchronous reset, active high.
   input wire logic [6:0] mgmt_address, // Management register address.
   input wire logic mgmt_write, // Management write strobe.
   input wire logic mgmt_read, // Management read strobe.
   input wire logic [31:0] mgmt_writedata, // Management write data.
   output logic [31:0] mgmt_readdata, // Management read data.
   output logic mgmt_readdatavalid, // Read data valid pulse.
   output logic [31:0] img_address, // Image memory word address.
   output logic img_read, // Image read request, held until valid.
   input wire logic [15:0] img_readdata, // Image record.
   input wire logic img_readdatavalid, // Image record valid.
   output logic xcvr_req, // Transceiver access request, held until done.
   output logic xcvr_we, // Transceiver access is a write.
   output logic [9:0] xcvr_channel, // Physical channel address.
   output logic [15:0] xcvr_offset, // Transceiver register offset.
   output logic [31:0] xcvr_wdata, // Transceiver write data.
   input wire logic [31:0] xcvr_rdata, // Transceiver read data.
   input wire logic xcvr_done, // Transceiver access complete.
   input wire logic xcvr_fail, // Transceiver access failed, with done.
   input wire logic [6:0] fabric_width, // Configured fabric width per lane.
   output logic [trs_pkg::NUM_LANES*trs_pkg::LANE_SLOT-1:0] lane_valid_mask, // 10G lanes.
   output logic [trs_pkg::STD_TX_WIDTH-1:0] std_tx_valid_mask, // Standard TX.
   output logic [trs_pkg::STD_RX_WIDTH-1:0] std_rx_valid_mask // Standard RX.
);
   trs_pkg::trs_state_e state_reg;
   logic [9:0] lch_reg;
   logic [1:0] mode_reg;
   logic csr_err_reg;
   logic [15:0] ofs_reg;
   logic [31:0] data_reg;
   logic [31:0] base_reg;
   logic [4:0] ierr_reg;
   logic [31:0] rec_idx_reg;
   logic first_reg;
   logic [4:0] count_reg;
   logic [10:0] wofs_reg;
   logic rmw_reg;
   logic sw_reg;
   logic [15:0] rec_reg;
   logic [31:0] old_reg;
   logic [9:0] phys;
   logic ch_valid;
   logic [1:0] ch_type;
   logic busy;
   logic wr_csr;
   logic start_wr;
   logic start_rd;
   logic start_stream;
   logic clear_err;
   logic [4:0] rec_len;
   logic [4:0] rec_opc;
   logic [31:0] rd_mux;

   // Flags an offset that the selected mode cannot reach.
   function automatic logic ofs_bad(input logic [1:0] mode, input logic [15:0] ofs);
      ofs_bad = (mode == trs_pkg::MODE_STREAM) ? ofs > trs_pkg::IREG_START
         : ofs >= trs_pkg::XCVR_OFS_LIMIT;
   endfunction

   // Bits at this offset that startup calibration owns.
   function automatic logic [31:0] prot_mask(input logic [15:0] ofs);
      prot_mask = (ofs >= trs_pkg::PROT_OFS_LO && ofs <= trs_pkg::PROT_OFS_HI)
         ? trs_pkg::PROT_MASK : 32'h0000_0000;
   endfunction

   trs_chan_map u_map (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .logical_ch(lch_reg),
      .phys_reg(phys),
      .valid_reg(ch_valid),
      .type_reg(ch_type)
   );

   assign busy = state_reg != trs_pkg::ST_IDLE;
   assign wr_csr = mgmt_write && mgmt_address == trs_pkg::ADDR_CSR;
   assign start_wr = wr_csr && mgmt_writedata[trs_pkg::CSR_WR] && !busy;
   assign start_rd = wr_csr && mgmt_writedata[trs_pkg::CSR_RD] && !start_wr && !busy;
   // Internal register writes happen through the write trigger in stream mode.
   assign start_stream = start_wr && mode_reg == trs_pkg::MODE_STREAM && ch_valid
      && ofs_reg == trs_pkg::IREG_START && data_reg[0] && ierr_reg == 5'h00;
   assign clear_err = start_wr && mode_reg == trs_pkg::MODE_STREAM
      && ofs_reg == trs_pkg::IREG_CLR && data_reg[0];
   assign rec_len = img_readdata[15:trs_pkg::REC_LEN_LO];
   assign rec_opc = img_readdata[4:0];

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         lch_reg <= 10'h000;
         mode_reg <= trs_pkg::MODE_STREAM;
         ofs_reg <= 16'h0000;
      end else if (mgmt_write && !busy) begin
         if (mgmt_address == trs_pkg::ADDR_LCH) begin
            lch_reg <= mgmt_writedata[9:0];
         end
         if (mgmt_address == trs_pkg::ADDR_OFS) begin
            ofs_reg <= mgmt_writedata[15:0];
         end
         if (wr_csr) begin
            mode_reg <= mgmt_writedata[trs_pkg::CSR_MODE_LO +: 2];
         end
      end
   end

   // Base address register, internal register zero.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         base_reg <= 32'h0000_0000;
      end else if (start_wr && mode_reg == trs_pkg::MODE_STREAM
         && ofs_reg == trs_pkg::IREG_BASE) begin
         base_reg <= data_reg;
      end
   end

   // Data register: host writes, internal reads, transceiver read results.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         data_reg <= 32'h0000_0000;
      end else if (mgmt_write && !busy && mgmt_address == trs_pkg::ADDR_DAT) begin
         data_reg <= mgmt_writedata;
      end else if (start_rd && mode_reg == trs_pkg::MODE_STREAM) begin
         unique case (ofs_reg)
            trs_pkg::IREG_BASE: data_reg <= base_reg;
            trs_pkg::IREG_START: data_reg <= {27'h0, ierr_reg[4:1], 1'b0};
            default: data_reg <= 32'h0000_0000;
         endcase
      end else if (state_reg == trs_pkg::ST_XREAD && xcvr_done && !rmw_reg) begin
         data_reg <= xcvr_rdata;
      end
   end

   // Sticky streaming errors; a new error wins over a clear in the same cycle.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ierr_reg <= 5'h00;
      end else begin
         logic [4:0] set_v;
         set_v = 5'h00;
         if ((start_wr || start_rd) && mode_reg == trs_pkg::MODE_STREAM
            && ofs_bad(mode_reg, ofs_reg)) begin
            set_v[trs_pkg::ERR_ACCESS] = 1'b1;
         end
         if (state_reg == trs_pkg::ST_WAIT && img_readdatavalid) begin
            if (first_reg ? (img_readdata != {5'h00, 6'h00, trs_pkg::OPC_START})
               : (count_reg == 5'h00 && rec_len == 5'h00
               && !(rec_opc inside {trs_pkg::OPC_START, trs_pkg::OPC_FORMAT,
               trs_pkg::OPC_CDR_SW, trs_pkg::OPC_PLL_SW, trs_pkg::OPC_END}))) begin
               set_v[trs_pkg::ERR_OPCODE] = 1'b1;
            end
            if (!first_reg && count_reg == 5'h00 && rec_len == 5'h00
               && rec_opc == trs_pkg::OPC_FORMAT
               && img_readdata[trs_pkg::REC_TYPE_LO +: 2] != ch_type) begin
               set_v[trs_pkg::ERR_MISMATCH] = 1'b1;
            end
         end
         if (state_reg == trs_pkg::ST_SWRITE && xcvr_done && xcvr_fail && sw_reg) begin
            set_v[trs_pkg::ERR_PLL] = 1'b1;
         end
         ierr_reg <= (clear_err ? 5'h00 : ierr_reg) | set_v;
      end
   end

   // Error bit of the control register covers channel, offset and mode faults and failed transceiver accesses.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         csr_err_reg <= 1'b0;
      end else if (start_wr || start_rd) begin
         csr_err_reg <= !ch_valid || ofs_bad(mode_reg, ofs_reg)
            || mode_reg[1];
      end else if (busy && xcvr_done && xcvr_fail) begin
         csr_err_reg <= 1'b1;
      end
   end

   // Operation sequencer for direct accesses and image streaming.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_reg <= trs_pkg::ST_IDLE;
         rec_idx_reg <= 32'h0000_0000;
         first_reg <= 1'b0;
         count_reg <= 5'h00;
         wofs_reg <= 11'h000;
         rmw_reg <= 1'b0;
         sw_reg <= 1'b0;
         rec_reg <= 16'h0000;
         old_reg <= 32'h0000_0000;
      end else begin
         unique case (state_reg)
            trs_pkg::ST_IDLE: begin
               if (start_stream) begin
                  state_reg <= trs_pkg::ST_FETCH;
                  rec_idx_reg <= 32'h0000_0000;
                  first_reg <= 1'b1;
                  count_reg <= 5'h00;
               end else if ((start_wr || start_rd) && mode_reg == trs_pkg::MODE_DIRECT
                  && ch_valid && !ofs_bad(mode_reg, ofs_reg)) begin
                  // A write reads first so protected bits can be merged back.
                  state_reg <= trs_pkg::ST_XREAD;
                  rmw_reg <= start_wr;
               end
            end
            trs_pkg::ST_XREAD: begin
               if (xcvr_done) begin
                  // Read data stands only with done, so keep it for the merge.
                  old_reg <= xcvr_rdata;
                  state_reg <= (rmw_reg && !xcvr_fail) ? trs_pkg::ST_XWRITE
                     : trs_pkg::ST_IDLE;
               end
            end
            trs_pkg::ST_XWRITE: begin
               if (xcvr_done) begin
                  state_reg <= trs_pkg::ST_IDLE;
                  rmw_reg <= 1'b0;
               end
            end
            trs_pkg::ST_FETCH: begin
               state_reg <= trs_pkg::ST_WAIT;
            end
            trs_pkg::ST_WAIT: begin
               if (img_readdatavalid) begin
                  rec_idx_reg <= rec_idx_reg + 32'h0000_0001;
                  rec_reg <= img_readdata;
                  first_reg <= 1'b0;
                  sw_reg <= 1'b0;
                  if (first_reg) begin
                     state_reg <= (img_readdata == {11'h000, trs_pkg::OPC_START})
                        ? trs_pkg::ST_FETCH : trs_pkg::ST_IDLE;
                  end else if (count_reg != 5'h00) begin
                     count_reg <= count_reg - 5'h01;
                     state_reg <= trs_pkg::ST_SWRITE;
                  end else if (rec_len != 5'h00) begin
                     count_reg <= rec_len;
                     wofs_reg <= img_readdata[10:0];
                     state_reg <= trs_pkg::ST_FETCH;
                  end else begin
                     unique case (rec_opc)
                        trs_pkg::OPC_START: state_reg <= trs_pkg::ST_FETCH;
                        trs_pkg::OPC_FORMAT: begin
                           state_reg <= (img_readdata[trs_pkg::REC_TYPE_LO +: 2] == ch_type)
                              ? trs_pkg::ST_FETCH : trs_pkg::ST_IDLE;
                        end
                        trs_pkg::OPC_CDR_SW, trs_pkg::OPC_PLL_SW: begin
                           state_reg <= trs_pkg::ST_SWRITE;
                           sw_reg <= 1'b1;
                        end
                        trs_pkg::OPC_END: state_reg <= trs_pkg::ST_IDLE;
                        default: state_reg <= trs_pkg::ST_IDLE;
                     endcase
                  end
               end
            end
            trs_pkg::ST_SWRITE: begin
               if (xcvr_done) begin
                  // A failed transceiver write stops the image and keeps the flags.
                  state_reg <= xcvr_fail ? trs_pkg::ST_IDLE : trs_pkg::ST_FETCH;
               end
            end
            default: state_reg <= trs_pkg::ST_IDLE;
         endcase
      end
   end

   // Image memory read port.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         img_read <= 1'b0;
         img_address <= 32'h0000_0000;
      end else if (state_reg == trs_pkg::ST_FETCH) begin
         img_read <= 1'b1;
         img_address <= base_reg + rec_idx_reg;
      end else if (img_readdatavalid) begin
         img_read <= 1'b0;
      end
   end

   // Transceiver access port.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         xcvr_req <= 1'b0;
         xcvr_we <= 1'b0;
         xcvr_channel <= 10'h000;
         xcvr_offset <= 16'h0000;
         xcvr_wdata <= 32'h0000_0000;
      end else if (xcvr_req) begin
         if (xcvr_done) begin
            xcvr_req <= 1'b0;
         end
      end else if (state_reg == trs_pkg::ST_XREAD) begin
         xcvr_req <= 1'b1;
         xcvr_we <= 1'b0;
         xcvr_channel <= phys;
         xcvr_offset <= ofs_reg;
      end else if (state_reg == trs_pkg::ST_XWRITE && !xcvr_done) begin
         xcvr_req <= 1'b1;
         xcvr_we <= 1'b1;
         xcvr_wdata <= (data_reg & ~prot_mask(ofs_reg))
            | (old_reg & prot_mask(ofs_reg));
      end else if (state_reg == trs_pkg::ST_SWRITE && !xcvr_done) begin
         xcvr_req <= 1'b1;
         xcvr_we <= 1'b1;
         xcvr_channel <= phys;
         if (sw_reg) begin
            xcvr_offset <= (rec_reg[4:0] == trs_pkg::OPC_CDR_SW)
               ? trs_pkg::XCVR_CDR_SW_OFS : trs_pkg::XCVR_PLL_SW_OFS;
            xcvr_wdata <= {29'h0, rec_reg[7:5]};
         end else begin
            xcvr_offset <= {5'h00, wofs_reg};
            xcvr_wdata <= {16'h0000, rec_reg};
         end
      end
   end

   // Management read answers one cycle after the strobe.
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (mgmt_address)
         trs_pkg::ADDR_LCH: rd_mux = {22'h0, lch_reg};
         trs_pkg::ADDR_PCH: rd_mux = {22'h0, phys};
         trs_pkg::ADDR_CSR: rd_mux = {22'h0, csr_err_reg, busy, 4'h0, mode_reg, 2'h0};
         trs_pkg::ADDR_OFS: rd_mux = {16'h0, ofs_reg};
         trs_pkg::ADDR_DAT: rd_mux = data_reg;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         mgmt_readdata <= 32'h0000_0000;
         mgmt_readdatavalid <= 1'b0;
      end else begin
         mgmt_readdatavalid <= mgmt_read;
         if (mgmt_read) begin
            mgmt_readdata <= rd_mux;
         end
      end
   end

   // Valid-bit masks of the wide fabric buses.
   genvar gl;
   generate
      for (gl = 0; gl < trs_pkg::NUM_LANES * trs_pkg::LANE_SLOT; gl++) begin : g_lane
         always_ff @(posedge core_clk) begin
            if (sys_rst) begin
               lane_valid_mask[gl] <= 1'b0;
            end else begin
               lane_valid_mask[gl] <= 7'(gl % trs_pkg::LANE_SLOT) < fabric_width;
            end
         end
      end
      for (gl = 0; gl < trs_pkg::STD_RX_WIDTH; gl++) begin : g_std
         always_ff @(posedge core_clk) begin
            if (sys_rst) begin
               std_rx_valid_mask[gl] <= 1'b0;
            end else begin
               std_rx_valid_mask[gl] <= 7'(gl) < fabric_width;
            end
         end
      end
   endgenerate
   assign std_tx_valid_mask = std_rx_valid_mask[trs_pkg::STD_TX_WIDTH-1:0];
endmodule

// ===== test/trs_streamer_monitor.sv
// Port timing checker for the reconfiguration streamer.
// Bound into trs_streamer and sees only its ports.
`timescale 1ns/1ps
module trs_streamer_monitor (
   input wire logic core_clk, // Clock.
   input wire logic sys_rst, // Reset.
   input wire logic [6:0] mgmt_address, // Address.
   input wire logic mgmt_read, // Read strobe.
   input wire logic [31:0] mgmt_readdata, // Read data.
   input wire logic mgmt_readdatavalid, // Read valid.
   input wire logic [31:0] img_address, // Image address.
   input wire logic img_read, // Image read.
   input wire logic img_readdatavalid, // Image valid.
   input wire logic xcvr_req, // Request.
   input wire logic xcvr_done, // Done.
   input wire logic [15:0] xcvr_offset, // Offset.
   input wire logic [6:0] fabric_width, // Lane width.
   input wire logic [191:0] lane_valid_mask, // Lane mask.
   input wire logic [63:0] std_rx_valid_mask // RX mask.
);
   logic [63:0] wmask;
   assign wmask = (fabric_width >= 7'h40) ? '1 : (64'h1 << fabric_width) - 64'h1;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   sequence s_steady;
      !sys_rst && $stable(fabric_width) ##1 $stable(fabric_width);
   endsequence
   sequence s_img_wait;
      img_read && !img_readdatavalid;
   endsequence
   sequence s_x_wait;
      xcvr_req && !xcvr_done;
   endsequence
   AST_RD_ANSWER: assert property (mgmt_read |=> mgmt_readdatavalid)
      else $error("read not answered");
   AST_RD_QUIET: assert property (!mgmt_read |=> !mgmt_readdatavalid)
      else $error("read valid without read");
   AST_CSR_RSV: assert property (mgmt_read && mgmt_address == trs_pkg::ADDR_CSR |=>
      mgmt_readdata[31:10] == '0 && mgmt_readdata[7:4] == '0 && mgmt_readdata[1:0] == '0)
      else $error("reserved or trigger bits read nonzero");
   AST_IMG_HOLD: assert property (s_img_wait |=> img_read && $stable(img_address))
      else $error("image request dropped early");
   AST_IMG_DROP: assert property (img_read && img_readdatavalid |=> !img_read)
      else $error("image request held after record");
   AST_X_HOLD: assert property (s_x_wait |=> xcvr_req && $stable(xcvr_offset))
      else $error("transceiver request not held");
   AST_X_DROP: assert property (xcvr_done |=> !xcvr_req)
      else $error("transceiver request held after done");
   AST_LANE_MASK: assert property (s_steady |-> std_rx_valid_mask == wmask &&
      lane_valid_mask == {3{wmask}})
      else $error("lane valid mask wrong");
endmodule
bind trs_streamer trs_streamer_monitor u_trs_streamer_monitor (.*);

// ===== test/trs_partner.sv
// Far side model: image memory and transceiver register file.
// Assumes the streamer holds each request until this model answers.
`timescale 1ns/1ps
module trs_partner (
   input wire logic core_clk, // Clock.
   input wire logic [31:0] img_address, // Record address.
   input wire logic img_read, // Record request.
   output logic [15:0] img_readdata, // Record.
   output logic img_readdatavalid, // Record valid.
   input wire logic xcvr_req, // Request.
   input wire logic xcvr_we, // Write.
   input wire logic [15:0] xcvr_offset, // Offset.
   input wire logic [31:0] xcvr_wdata, // Write data.
   output logic [31:0] xcvr_rdata, // Read data.
   output logic xcvr_done, // Done.
   output logic xcvr_fail, // Failed.
   input wire logic [1:0] lat, // Delay.
   input wire logic fail_sw // Fail switches.
);
   logic [15:0] mem [0:63];
   logic [31:0] regs [0:31];
   int ic = 0;
   int xc = 0;
   initial begin
      img_readdata = 16'h0;
      xcvr_rdata = 32'h0;
   end
   // Idle data lines toggle so a stale value never passes for an answer.
   always @(posedge core_clk) begin
      img_readdatavalid <= 1'b0;
      img_readdata <= ~img_readdata;
      ic <= 0;
      if (img_read && !img_readdatavalid) begin
         ic <= ic + 1;
         if (ic >= lat) begin
            ic <= 0;
            img_readdatavalid <= 1'b1;
            img_readdata <= mem[img_address[5:0]];
         end
      end
   end
   always @(posedge core_clk) begin
      xcvr_done <= 1'b0;
      xcvr_fail <= 1'b0;
      xcvr_rdata <= ~xcvr_rdata;
      xc <= 0;
      if (xcvr_req && !xcvr_done) begin
         xc <= xc + 1;
         if (xc >= lat) begin
            xc <= 0;
            xcvr_done <= 1'b1;
            xcvr_fail <= fail_sw && xcvr_offset >= 16'h0800;
            xcvr_rdata <= regs[xcvr_offset[4:0]];
            if (xcvr_we && xcvr_offset < 16'h0800) regs[xcvr_offset[4:0]] <= xcvr_wdata;
         end
      end
   end
endmodule

// ===== test/tb_trs_streamer.sv
// Self-checking bench for the reconfiguration streamer and its far side.
// Assumes trs_partner models the image memory and the transceiver.
`timescale 1ns/1ps
module tb_trs_streamer;
   logic core_clk = 1'b0, sys_rst = 1'b1, mgmt_write = 1'b0, mgmt_read = 1'b0, fail_sw = 1'b0;
   logic [6:0] mgmt_address = 7'h00, fabric_width = 7'h20;
   logic [31:0] mgmt_writedata = 32'h0, mgmt_readdata, img_address, xcvr_rdata, xcvr_wdata;
   logic [15:0] img_readdata, xcvr_offset;
   logic mgmt_readdatavalid, img_read, img_readdatavalid, xcvr_req, xcvr_we, xcvr_done, xcvr_fail;
   logic [9:0] xcvr_channel;
   logic [191:0] lane_valid_mask;
   logic [43:0] std_tx_valid_mask;
   logic [63:0] std_rx_valid_mask, wm;
   logic [1:0] lat = 2'h0;
   logic [31:0] seed = 32'h0001_1A96, d, r, xr [0:31];
   logic [15:0] pv [4] = '{16'h0002, 16'h0042, 16'h0005, 16'h0003};
   logic [31:0] pe [4] = '{32'h2, 32'h10, 32'h2, 32'h4};
   int pi [4] = '{0, 1, 1, 1};
   int fail_count = 0, n_tests = 0, b, k, ch;
   trs_streamer u_trs_streamer (.*);
   trs_partner u_trs_partner (.*);
   initial forever #2.5 core_clk = ~core_clk;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   always @(posedge core_clk) lat <= 2'(rnd());
   task automatic chk(input logic [63:0] e, input logic [63:0] g);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("BAD t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [31:0] v);
      @(posedge core_clk);
      mgmt_address <= a;
      mgmt_writedata <= v;
      mgmt_write <= 1'b1;
      @(posedge core_clk);
      mgmt_write <= 1'b0;
   endtask
   task automatic rd(input logic [6:0] a);
      @(posedge core_clk);
      mgmt_address <= a;
      mgmt_read <= 1'b1;
      @(posedge core_clk);
      mgmt_read <= 1'b0;
      @(posedge core_clk);
      d = mgmt_readdata;
   endtask
   task automatic idle();
      repeat (100) begin
         rd(trs_pkg::ADDR_CSR);
         if (d[8] === 1'b0) break;
      end
      chk(0, d[8]);
   endtask
   task automatic iw(input logic [1:0] m, input logic [15:0] a, input logic [31:0] v);
      wr(trs_pkg::ADDR_OFS, {16'h0, a});
      wr(trs_pkg::ADDR_DAT, v);
      wr(trs_pkg::ADDR_CSR, {28'h0, m, 2'b01});
      idle();
   endtask
   task automatic ir(input logic [1:0] m, input logic [15:0] a);
      wr(trs_pkg::ADDR_OFS, {16'h0, a});
      wr(trs_pkg::ADDR_CSR, {28'h0, m, 2'b10});
      idle();
      rd(trs_pkg::ADDR_DAT);
   endtask
   task automatic img(input logic [15:0] v);
      u_trs_partner.mem[b] = 16'h0001;
      u_trs_partner.mem[b+1] = 16'h0002;
      u_trs_partner.mem[b+2] = 16'h1005;
      u_trs_partner.mem[b+3] = 16'(rnd());
      u_trs_partner.mem[b+4] = v;
      u_trs_partner.mem[b+5] = 16'h001F;
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #100000;
      fail_count++;
      finish_test();
   end
   initial begin
      fabric_width = 7'(rnd() % 64 + 1);
      for (k = 0; k < 32; k++) begin
         xr[k] = rnd();
         u_trs_partner.regs[k] = xr[k];
      end
      repeat (3) @(posedge core_clk);
      sys_rst <= 1'b0;
      rd(trs_pkg::ADDR_CSR);
      chk(0, d);
      wm = (fabric_width == 7'h40) ? '1 : (64'h1 << fabric_width) - 64'h1;
      chk(wm[43:0], std_tx_valid_mask);
      chk(wm, lane_valid_mask[191:128]);
      $display("test 1 done");
      ch = rnd() % 4;
      wr(trs_pkg::ADDR_LCH, ch);
      rd(trs_pkg::ADDR_PCH);
      chk(ch, d);
      wr(trs_pkg::ADDR_CSR, 32'h4);
      rd(trs_pkg::ADDR_CSR);
      chk(32'h4, d);
      for (k = 0; k < 2; k++) begin
         r = rnd();
         b = k ? 16'h1C : 16'h11;
         iw(2'h1, 16'(b), r);
         xr[b] = k ? r : (r & ~32'hFF) | (xr[b] & 32'hFF);
         chk(xr[b], u_trs_partner.regs[b]);
         ir(2'h1, 16'(b));
         chk(xr[b], d);
      end
      chk(ch, xcvr_channel);
      $display("test 2 done");
      wr(trs_pkg::ADDR_CSR, 32'h0);
      b = 8 + rnd() % 8;
      iw(2'h0, 16'h0, b);
      ir(2'h0, 16'h0);
      chk(b, d);
      r = rnd();
      img(r[15:0]);
      wr(trs_pkg::ADDR_OFS, 32'h2);
      wr(trs_pkg::ADDR_DAT, 32'h1);
      wr(trs_pkg::ADDR_CSR, 32'h1);
      rd(trs_pkg::ADDR_CSR);
      chk(1, d[8]);
      idle();
      chk({16'h0, r[15:0]}, u_trs_partner.regs[5]);
      ir(2'h0, 16'h2);
      chk(0, d);
      $display("test 3 done");
      for (k = 0; k < 4; k++) begin
         img(16'(rnd()));
         u_trs_partner.mem[b + pi[k]] = pv[k];
         fail_sw <= (k == 3);
         iw(2'h0, 16'h2, 32'h1);
         ir(2'h0, 16'h2);
         chk(pe[k], d);
         xr[5] = u_trs_partner.regs[5];
         img(16'(rnd()));
         iw(2'h0, 16'h2, 32'h1);
         chk(xr[5], u_trs_partner.regs[5]);
         iw(2'h0, 16'h1, 32'h1);
         ir(2'h0, 16'h2);
         chk(0, d);
      end
      r = rnd();
      img(r[15:0]);
      iw(2'h0, 16'h2, 32'h1);
      chk({16'h0, r[15:0]}, u_trs_partner.regs[5]);
      iw(2'h0, 16'h5, r);
      chk(32'h200, d);
      ir(2'h0, 16'h0);
      wr(trs_pkg::ADDR_CSR, 32'h8);
      wr(trs_pkg::ADDR_CSR, 32'h9);
      rd(trs_pkg::ADDR_CSR);
      chk(32'h208, d);
      $display("test 4 done");
      finish_test();
   end
endmodule
